// File: logic/pmx_pkg.sv
// shared constants for the port a to d pin function multiplexer
package pmx_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int PMX_NUM_PINS = 32;
	localparam logic [11:0] PMX_CFG_BASE = 12'h000;
	localparam logic [11:0] PMX_LEVEL_ADDR = 12'h080;
	localparam int PMX_SEL_LSB = 0;
	localparam int PMX_SEL_WIDTH = 6;
	localparam int PMX_SEL_WIDTH_OLD = 5;
	localparam int PMX_INTERRUPT_INPUT_SELECT_BIT = 6;
	localparam logic [7:0] PMX_CFG_RESET = 8'h00;
	localparam logic [31:0] PMX_LEVEL_RESET = 32'h0000_0000;

	// ----------------------------------------
	// pin indices: port a 0..7, b 8..15, c 16..23, d 24..31
	// ----------------------------------------
	localparam int PIN_A0 = 0;
	localparam int PIN_A1 = 1;
	localparam int PIN_A6 = 6;
	localparam int PIN_B0 = 8;
	localparam int PIN_B1 = 9;
	localparam int PIN_B2 = 10;
	localparam int PIN_B3 = 11;
	localparam int PIN_B4 = 12;
	localparam int PIN_B6 = 14;
	localparam int PIN_D0 = 24;
	localparam int PIN_D4 = 28;

	// ----------------------------------------
	// selection codes
	// ----------------------------------------
	localparam logic [5:0] SEL_HIZ = 6'h00;
	localparam logic [5:0] SEL_TMR_IO = 6'h01;
	localparam logic [5:0] SEL_TMR_CLK_D = 6'h02;
	localparam logic [5:0] SEL_TMR_ALT = 6'h03;
	localparam logic [5:0] SEL_OUT_DISABLE = 6'h07;
	localparam logic [5:0] SEL_ADC = 6'h09;
	localparam logic [5:0] SEL_I2C = 6'h0F;
	localparam logic [5:0] SEL_CAN = 6'h10;
	localparam logic [5:0] SEL_USB = 6'h11;
	localparam logic [5:0] SEL_PWM_A = 6'h14;
	localparam logic [5:0] SEL_PWM_B = 6'h15;
	localparam logic [5:0] SEL_PWM_C = 6'h16;
	localparam logic [5:0] SEL_PWM_D = 6'h17;

	// ----------------------------------------
	// interrupt request lines of port b
	// ----------------------------------------
	localparam int IRQ_B0 = 8;
	localparam int IRQ_B1 = 4;
	localparam int IRQ_B3 = 9;
	localparam int IRQ_B4 = 3;
	localparam int IRQ_B6 = 2;
	localparam int PMX_NUM_IRQ = 16;
endpackage

// File: logic/pmx_pin_mux_top.sv
// pin function multiplexer for ports a to d with apb register access
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pmx_pin_mux_top #(
	parameter bit OLD_VARIANT = 1'b0
) (
	input wire logic clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pads
	input wire logic [pmx_pkg::PMX_NUM_PINS-1:0] padIn,
	output logic [pmx_pkg::PMX_NUM_PINS-1:0] padOut,
	output logic [pmx_pkg::PMX_NUM_PINS-1:0] padOe,
	// peripheral outputs toward pins
	input wire logic pulseTimerCh6IoCOut,
	input wire logic pulseTimerCh6IoCOe,
	input wire logic canPort0Transmit,
	input wire logic i2cCh0ClockLow,
	input wire logic i2cCh0DataLow,
	input wire logic pwmTimerCh2IoAOut,
	input wire logic pwmTimerCh2IoAOe,
	input wire logic pwmTimerCh2IoBOut,
	input wire logic pwmTimerCh2IoBOe,
	input wire logic pwmTimerCh0IoBOut,
	input wire logic pwmTimerCh0IoBOe,
	input wire logic adcUnit0ConversionStart,
	// peripheral inputs from pins
	output logic pulseTimerCh6IoCIn,
	output logic pulseTimerCh6IoCAltIn,
	output logic canPort0Receive,
	output logic adcUnit0ExternalTriggerN,
	output logic pulseTimerExtClockB,
	output logic pulseTimerExtClockBAlt,
	output logic pulseTimerExtClockD,
	output logic i2cCh0ClockLine,
	output logic i2cCh0DataLine,
	output logic outputDisableRequest8N,
	output logic [3:0] pwmTimerExtTrigger,
	output logic usbOvercurrentInputA,
	output logic pwmTimerCh2IoAIn,
	output logic pwmTimerCh0IoBIn,
	output logic usbBusPowerDetect,
	output logic pwmTimerCh2IoBIn,
	output logic [pmx_pkg::PMX_NUM_IRQ-1:0] irqRequest
);
	import pmx_pkg::*;

	// ----------------------------------------
	// storage and helpers
	// ----------------------------------------
	// one config byte per pin: [5:0] code, [6] interrupt select, [7] always 0
	logic [7:0] cfg_q [PMX_NUM_PINS];
	logic [PMX_NUM_PINS-1:0] sync1_q, sync2_q, sync3_q, level_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic [PMX_NUM_PINS-1:0] padOut_d, padOe_d, padOut_q, padOe_q;
	logic [PMX_NUM_IRQ-1:0] irq_d, irq_q;
	logic setupPhase, accessWrite, addrInCfg;
	logic [4:0] addrIdx;

	// selection code of a pin; the older variant never has bit 5 set
	function automatic logic [5:0] selOf(input logic [7:0] cfg);
		logic [5:0] code;
		code = cfg[PMX_SEL_LSB +: PMX_SEL_WIDTH];
		if (OLD_VARIANT) begin
			code[PMX_SEL_WIDTH-1] = 1'b0;
		end
		return code;
	endfunction

	// the alternate-marked codes only exist on the newer field
	function automatic logic altOk(input logic [5:0] code, input logic [5:0] want);
		return !OLD_VARIANT && code == want;
	endfunction

	// bus decode; a write lands only in an access phase that the slave marks ready
	assign setupPhase = psel && !penable;
	assign accessWrite = psel && penable && pwrite && pready_q;
	assign addrInCfg = paddr[11:7] == PMX_CFG_BASE[11:7];
	assign addrIdx = paddr[6:2];

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// answer is computed in setup so the access phase completes with no wait state
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			pready_q <= 1'b0;
		end else begin
			pready_q <= 1'b1;
			if (setupPhase) begin
				pslverr_q <= !(addrInCfg || paddr == PMX_LEVEL_ADDR) || paddr[1:0] != 2'b00;
				if (paddr == PMX_LEVEL_ADDR) begin
					prdata_q <= level_q;
				end else if (addrInCfg) begin
					// bit 7 is never stored, so it always reads back as 0
					prdata_q <= {24'h00_0000, 1'b0, cfg_q[addrIdx][PMX_INTERRUPT_INPUT_SELECT_BIT], 
						selOf(cfg_q[addrIdx])};
				end else begin
					prdata_q <= 32'h0000_0000;
				end
			end
		end
	end

	// configuration registers; level register and unmapped writes are dropped
	// only byte lane 0 matters: each config register is one byte wide, upper lanes are ignored
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < PMX_NUM_PINS; i++) begin
				cfg_q[i] <= PMX_CFG_RESET;
			end
		end else if (accessWrite && addrInCfg && pstrb[0] && paddr[1:0] == 2'b00) begin
			cfg_q[addrIdx] <= {1'b0, pwdata[PMX_INTERRUPT_INPUT_SELECT_BIT], selOf(pwdata[7:0])};
		end
	end

	// ----------------------------------------
	// pad input synchronisers
	// ----------------------------------------
	// a level is accepted only once the second and third stages agree, which drops one-cycle glitches
	// the first stage may be metastable, so nothing but the second stage reads it
	genvar g;
	generate
		for (g = 0; g < PMX_NUM_PINS; g++) begin : gSync
			always_ff @(posedge clk) begin
				if (!nrst) begin
					sync1_q[g] <= 1'b0;
					sync2_q[g] <= 1'b0;
					sync3_q[g] <= 1'b0;
					level_q[g] <= PMX_LEVEL_RESET[g];
				end else begin
					sync1_q[g] <= padIn[g];
					sync2_q[g] <= sync1_q[g];
					sync3_q[g] <= sync2_q[g];
					if (sync2_q[g] == sync3_q[g]) begin
						level_q[g] <= sync3_q[g];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// pad drive
	// ----------------------------------------
	// every pin floats unless a listed code on that pin asks for drive
	// limitation: only the drive routes listed per pin exist, every other code counts as reserved
	always_comb begin
		padOut_d = '0;
		padOe_d = '0;
		if (selOf(cfg_q[PIN_A0]) == SEL_TMR_IO || altOk(selOf(cfg_q[PIN_A0]), SEL_TMR_ALT)) begin
			padOut_d[PIN_A0] = pulseTimerCh6IoCOut;
			padOe_d[PIN_A0] = pulseTimerCh6IoCOe;
		end else if (selOf(cfg_q[PIN_A0]) == SEL_CAN) begin
			padOut_d[PIN_A0] = canPort0Transmit;
			padOe_d[PIN_A0] = 1'b1;
		end
		// i2c lines are open drain: only ever pulled low
		if (selOf(cfg_q[PIN_B1]) == SEL_I2C) begin
			padOe_d[PIN_B1] = i2cCh0ClockLow;
		end
		if (selOf(cfg_q[PIN_B2]) == SEL_I2C) begin
			padOe_d[PIN_B2] = i2cCh0DataLow;
		end
		if (selOf(cfg_q[PIN_B6]) == SEL_PWM_A) begin
			padOut_d[PIN_B6] = pwmTimerCh2IoAOut;
			padOe_d[PIN_B6] = pwmTimerCh2IoAOe;
		end
		if (selOf(cfg_q[PIN_D0]) == SEL_ADC) begin
			padOut_d[PIN_D0] = adcUnit0ConversionStart;
			padOe_d[PIN_D0] = 1'b1;
		end else if (selOf(cfg_q[PIN_D0]) == SEL_PWM_A) begin
			padOut_d[PIN_D0] = pwmTimerCh0IoBOut;
			padOe_d[PIN_D0] = pwmTimerCh0IoBOe;
		end
		if (selOf(cfg_q[PIN_D4]) == SEL_PWM_A) begin
			padOut_d[PIN_D4] = pwmTimerCh2IoBOut;
			padOe_d[PIN_D4] = pwmTimerCh2IoBOe;
		end
	end

	// pad drive is registered so the pins never see decode glitches
	always_ff @(posedge clk) begin
		if (!nrst) begin
			padOut_q <= '0;
			padOe_q <= '0;
		end else begin
			padOut_q <= padOut_d;
			padOe_q <= padOe_d;
		end
	end

	// ----------------------------------------
	// peripheral inputs
	// ----------------------------------------
	// an unselected input rests at its idle level: high for active-low, can receive and the i2c lines, low otherwise
	// the trade: one more cycle of latency buys peripheral inputs that never glitch on a code change
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pulseTimerCh6IoCIn <= 1'b0;
			pulseTimerCh6IoCAltIn <= 1'b0;
			canPort0Receive <= 1'b1;
			adcUnit0ExternalTriggerN <= 1'b1;
			pulseTimerExtClockB <= 1'b0;
			pulseTimerExtClockBAlt <= 1'b0;
			pulseTimerExtClockD <= 1'b0;
			i2cCh0ClockLine <= 1'b1;
			i2cCh0DataLine <= 1'b1;
			outputDisableRequest8N <= 1'b1;
			pwmTimerExtTrigger <= 4'h0;
			usbOvercurrentInputA <= 1'b0;
			pwmTimerCh2IoAIn <= 1'b0;
			pwmTimerCh0IoBIn <= 1'b0;
			usbBusPowerDetect <= 1'b0;
			pwmTimerCh2IoBIn <= 1'b0;
		end else begin
			pulseTimerCh6IoCIn <= selOf(cfg_q[PIN_A0]) == SEL_TMR_IO && level_q[PIN_A0];
			pulseTimerCh6IoCAltIn <= altOk(selOf(cfg_q[PIN_A0]), SEL_TMR_ALT) && level_q[PIN_A0];
			// pin a1 wins when both can receive sources are chosen
			if (selOf(cfg_q[PIN_A1]) == SEL_CAN) begin
				canPort0Receive <= level_q[PIN_A1];
			end else if (selOf(cfg_q[PIN_B6]) == SEL_CAN) begin
				canPort0Receive <= level_q[PIN_B6];
			end else begin
				canPort0Receive <= 1'b1;
			end
			adcUnit0ExternalTriggerN <= selOf(cfg_q[PIN_A1]) == SEL_ADC ? level_q[PIN_A1] : 1'b1;
			pulseTimerExtClockB <= selOf(cfg_q[PIN_A6]) == SEL_TMR_IO && level_q[PIN_A6];
			pulseTimerExtClockD <= selOf(cfg_q[PIN_A6]) == SEL_TMR_CLK_D && level_q[PIN_A6];
			pulseTimerExtClockBAlt <= altOk(selOf(cfg_q[PIN_A6]), SEL_TMR_ALT) && level_q[PIN_A6];
			i2cCh0ClockLine <= selOf(cfg_q[PIN_B1]) == SEL_I2C ? level_q[PIN_B1] : 1'b1;
			i2cCh0DataLine <= selOf(cfg_q[PIN_B2]) == SEL_I2C ? level_q[PIN_B2] : 1'b1;
			outputDisableRequest8N <= selOf(cfg_q[PIN_B4]) == SEL_OUT_DISABLE ? level_q[PIN_B4] : 1'b1;
			pwmTimerExtTrigger[0] <= selOf(cfg_q[PIN_B4]) == SEL_PWM_A && level_q[PIN_B4];
			pwmTimerExtTrigger[1] <= selOf(cfg_q[PIN_B4]) == SEL_PWM_B && level_q[PIN_B4];
			pwmTimerExtTrigger[2] <= selOf(cfg_q[PIN_B4]) == SEL_PWM_C && level_q[PIN_B4];
			pwmTimerExtTrigger[3] <= selOf(cfg_q[PIN_B4]) == SEL_PWM_D && level_q[PIN_B4];
			usbOvercurrentInputA <= selOf(cfg_q[PIN_B6]) == SEL_USB && level_q[PIN_B6];
			pwmTimerCh2IoAIn <= selOf(cfg_q[PIN_B6]) == SEL_PWM_A && level_q[PIN_B6];
			pwmTimerCh0IoBIn <= selOf(cfg_q[PIN_D0]) == SEL_PWM_A && level_q[PIN_D0];
			usbBusPowerDetect <= selOf(cfg_q[PIN_D4]) == SEL_USB && level_q[PIN_D4];
			pwmTimerCh2IoBIn <= selOf(cfg_q[PIN_D4]) == SEL_PWM_A && level_q[PIN_D4];
		end
	end

	// ----------------------------------------
	// interrupt routing
	// ----------------------------------------
	// interrupt select works beside the function field, so a pin can feed both at once
	always_comb begin
		// lines with no port b pin behind them stay low
		irq_d = '0;
		irq_d[IRQ_B0] = cfg_q[PIN_B0][PMX_INTERRUPT_INPUT_SELECT_BIT] && level_q[PIN_B0];
		irq_d[IRQ_B1] = cfg_q[PIN_B1][PMX_INTERRUPT_INPUT_SELECT_BIT] && level_q[PIN_B1];
		irq_d[IRQ_B3] = cfg_q[PIN_B3][PMX_INTERRUPT_INPUT_SELECT_BIT] && level_q[PIN_B3];
		irq_d[IRQ_B4] = cfg_q[PIN_B4][PMX_INTERRUPT_INPUT_SELECT_BIT] && level_q[PIN_B4];
		irq_d[IRQ_B6] = cfg_q[PIN_B6][PMX_INTERRUPT_INPUT_SELECT_BIT] && level_q[PIN_B6];
	end

	// registered so the interrupt lines change only on clock edges, like every other output
	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq_q <= '0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// ----------------------------------------
	// output ports
	// ----------------------------------------
	// every port is a plain copy of its flop, so no decode logic reaches a pin or a peripheral
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign padOut = padOut_q;
	assign padOe = padOe_q;
	assign irqRequest = irq_q;
endmodule

// File: sim/pmx_pin_mux_props.sv
// concurrent checks on the pin multiplexer ports
`timescale 1ns/1ps
module pmx_pin_mux_props (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [pmx_pkg::PMX_NUM_PINS-1:0] padIn,
	input wire logic [pmx_pkg::PMX_NUM_PINS-1:0] padOut,
	input wire logic [pmx_pkg::PMX_NUM_PINS-1:0] padOe,
	input wire logic canPort0Transmit,
	input wire logic i2cCh0ClockLow,
	input wire logic adcUnit0ConversionStart,
	input wire logic canPort0Receive,
	input wire logic [pmx_pkg::PMX_NUM_IRQ-1:0] irqRequest
);
	import pmx_pkg::*;
	logic [7:0] cfgShadow_q [PMX_NUM_PINS];
	wire wrHit = psel & penable & pwrite & pready & pstrb[0] & (paddr < PMX_LEVEL_ADDR) & (paddr[1:0] == 2'h0);
	// shadow of the config words, kept from bus writes alone
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < PMX_NUM_PINS; i++) cfgShadow_q[i] <= 8'h00;
		end else if (wrHit) begin
			cfgShadow_q[paddr[6:2]] <= pwdata[7:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_pready_start: assert property ($rose(nrst) |-> !pready ##1 pready)
		else $error("pready not up one edge after reset release");
	chk_slverr_map: assert property (psel && !penable && (paddr > 12'h080 || paddr[1:0] != 2'h0) |=> pslverr)
		else $error("no error for unmapped address");
	chk_irq_unused: assert property ((irqRequest & ~16'h031C) == 16'h0000)
		else $error("interrupt line outside the mapped set");
	chk_drive_mask: assert property ((padOe & ~32'h1100_4601) == 32'h0000_0000)
		else $error("input-only pin driven");
	chk_hiz_float: assert property (!($past(cfgShadow_q[0][5:0]) inside {6'h01, 6'h03, 6'h10})
		|-> !padOe[0])
		else $error("unselected pin a0 driven");
	chk_can_tx: assert property ($past(cfgShadow_q[0][5:0]) == 6'h10
		|-> padOe[0] && padOut[0] == $past(canPort0Transmit))
		else $error("can transmit not on pin a0");
	chk_adc_start: assert property ($past(cfgShadow_q[24][5:0]) == 6'h09
		|-> padOe[24] && padOut[24] == $past(adcUnit0ConversionStart))
		else $error("conversion start not on pin d0");
	chk_i2c_drain: assert property ($past(cfgShadow_q[9][5:0]) == 6'h0F
		|-> !padOut[9] && padOe[9] == $past(i2cCh0ClockLow))
		else $error("i2c clock pin not open drain");
	chk_can_rx: assert property ($past(cfgShadow_q[1][5:0]) == 6'h10
		&& $past(padIn[1], 5) == $past(padIn[1], 6) |-> canPort0Receive == $past(padIn[1], 5))
		else $error("can receive does not follow pin a1");
	chk_irq_level: assert property ($past(cfgShadow_q[8][6])
		&& $past(padIn[8], 5) == $past(padIn[8], 6) |-> irqRequest[8] == $past(padIn[8], 5))
		else $error("interrupt 8 does not follow pin b0");
	chk_irq_off: assert property (!$past(cfgShadow_q[11][6]) |-> !irqRequest[9])
		else $error("interrupt 9 raised with select clear");
endmodule

// File: sim/pmx_periph_model.sv
// stand-in for the peripherals that drive signals toward the pins
`timescale 1ns/1ps
module pmx_periph_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic outEn,
	output logic [11:0] drv
);
	logic [11:0] pat_q;
	// shifting pattern so that every cycle shows a fresh value
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pat_q <= 12'h5A3;
		end else begin
			pat_q <= {pat_q[10:0], ~^(pat_q & 12'h829)};
		end
	end
	// at rest all enables and open-drain pulls are released
	assign drv = outEn ? pat_q : 12'h000;
endmodule

// File: sim/tb.sv
// self-checking bench for the port a to d pin multiplexer
`timescale 1ns/1ps
module tb;
	import pmx_pkg::*;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, rdErr, outEn;
	logic [11:0] paddr;
	logic [3:0] pstrb;
	logic [8:0] prev;
	logic expBit;
	logic [31:0] pwdata, prdata, rdData, padDrv, padOut, padOe;
	logic [11:0] drv;
	logic [15:0] irq;
	wire [18:0] peri;
	wire [31:0] padIn = (padOe & padOut) | (~padOe & padDrv);
	// pad drive seen on the routed pins, and what the peripherals asked for
	wire [8:0] drvSeen = {padOut[0], padOut[24], padOe[9], padOe[0], padOut[14], padOe[14], padOut[28],
		padOe[28], padOe[10]};
	wire [8:0] drvWant = {drv[2], drv[11], drv[3], 1'b1, drv[5], drv[6], drv[7], drv[8], drv[4]};
	int n_mismatch, check_count, i, k;
	localparam int RPIN [20] = '{0, 0, 1, 1, 6, 6, 6, 9, 10, 12, 12, 12, 12, 12, 14, 14, 14, 24, 28, 28};
	localparam int RIDX [20] = '{0, 18, 2, 1, 3, 5, 4, 6, 7, 8, 9, 10, 11, 12, 1, 13, 14, 15, 16, 17};
	localparam logic [5:0] RCODE [20] = '{6'h01, 6'h03, 6'h09, 6'h10, 6'h01, 6'h02, 6'h03, 6'h0F, 6'h0F, 6'h07,
		6'h14, 6'h15, 6'h16, 6'h17, 6'h10, 6'h11, 6'h14, 6'h14, 6'h11, 6'h14};
	localparam int IPIN [5] = '{8, 9, 11, 12, 14};
	localparam logic [18:0] IDLE = 19'h0_01C6;
	pmx_pin_mux_top u_pmx_pin_mux_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.padIn(padIn), .padOut(padOut), .padOe(padOe), .pulseTimerCh6IoCOut(drv[0]), .pulseTimerCh6IoCOe(drv[1]),
		.canPort0Transmit(drv[2]), .i2cCh0ClockLow(drv[3]), .i2cCh0DataLow(drv[4]), .pwmTimerCh2IoAOut(drv[5]),
		.pwmTimerCh2IoAOe(drv[6]), .pwmTimerCh2IoBOut(drv[7]), .pwmTimerCh2IoBOe(drv[8]), .pwmTimerCh0IoBOut(drv[9]),
		.pwmTimerCh0IoBOe(drv[10]), .adcUnit0ConversionStart(drv[11]), .pulseTimerCh6IoCIn(peri[0]),
		.pulseTimerCh6IoCAltIn(peri[18]), .canPort0Receive(peri[1]), .adcUnit0ExternalTriggerN(peri[2]),
		.pulseTimerExtClockB(peri[3]), .pulseTimerExtClockBAlt(peri[4]), .pulseTimerExtClockD(peri[5]),
		.i2cCh0ClockLine(peri[6]), .i2cCh0DataLine(peri[7]), .outputDisableRequest8N(peri[8]),
		.pwmTimerExtTrigger(peri[12:9]), .usbOvercurrentInputA(peri[13]), .pwmTimerCh2IoAIn(peri[14]),
		.pwmTimerCh0IoBIn(peri[15]), .usbBusPowerDetect(peri[16]), .pwmTimerCh2IoBIn(peri[17]), .irqRequest(irq));
	pmx_periph_model u_pmx_periph_model (.clk(clk), .nrst(nrst), .outEn(outEn), .drv(drv));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s seen=%h exp=%h", $time, what, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			n_mismatch++;
			summarize();
		end
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// select a code, set the pad level and let the 5-edge path settle
	task automatic pin(input int p, input logic [5:0] c, input logic lvl);
		apb(1'b1, 12'(4 * p), 32'(c));
		@(posedge clk);
		padDrv[p] <= lvl;
		repeat (7) @(posedge clk);
		@(negedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ----
	// main sequence
	// ----
	initial begin
		{nrst, psel, penable, pwrite, outEn, paddr, pwdata, padDrv} = '0;
		pstrb = 4'hF;
		n_mismatch = 0;
		check_count = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		for (i = 0; i < 32; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0000_0000);
			check(rdData, 32'h0000_0000, "cfg reset");
		end
		apb(1'b1, 12'h00C, 32'h0000_00FF);
		apb(1'b0, 12'h00C, 32'h0000_0000);
		check(rdData, 32'h0000_007F, "cfg readback");
		check(32'(rdErr), 32'h0000_0000, "mapped no error");
		apb(1'b0, 12'h084, 32'h0000_0000);
		check(32'(rdErr), 32'h0000_0001, "unmapped error");
		apb(1'b0, 12'h002, 32'h0000_0000);
		check(32'(rdErr), 32'h0000_0001, "unaligned error");
		$display("register test done");
		// each route at both levels, then a reserved code and code zero
		for (i = 0; i < 20; i++) begin
			for (k = 0; k < 4; k++) begin
				pin(RPIN[i], k < 2 ? RCODE[i] : (k == 2 ? 6'h3F : 6'h00), k < 2 ? k[0] : ~IDLE[RIDX[i]]);
				expBit = k < 2 ? k[0] : IDLE[RIDX[i]];
				if (k >= 2) check(32'(peri[RIDX[i]]), 32'(expBit), "route off");
				else if (i < 7) check(32'(peri[RIDX[i]]), 32'(expBit), "route a");
				else if (i < 17) check(32'(peri[RIDX[i]]), 32'(expBit), "route b");
				else check(32'(peri[RIDX[i]]), 32'(expBit), "route d");
			end
		end
		$display("input route test done");
		apb(1'b1, 12'h000, 32'h0000_0010);
		apb(1'b1, 12'h060, 32'h0000_0009);
		apb(1'b1, 12'h024, 32'h0000_000F);
		apb(1'b1, 12'h028, 32'h0000_000F);
		apb(1'b1, 12'h038, 32'h0000_0014);
		apb(1'b1, 12'h070, 32'h0000_0014);
		@(posedge clk);
		outEn <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		prev = drvWant;
		for (i = 0; i < 16; i++) begin
			@(negedge clk);
			check(32'(drvSeen), 32'(prev), "pin drive");
			prev = drvWant;
		end
		$display("output route test done");
		for (i = 0; i < 5; i++) apb(1'b1, 12'(4 * IPIN[i]), 32'h0000_0040);
		@(posedge clk);
		padDrv <= 32'h0000_5B00;
		repeat (7) @(posedge clk);
		@(negedge clk);
		check(32'(irq), 32'h0000_031C, "irq map");
		apb(1'b0, 12'h080, 32'h0000_0000);
		check(rdData & 32'h0000_FF00, 32'h0000_5B00, "level read");
		for (i = 0; i < 5; i++) apb(1'b1, 12'(4 * IPIN[i]), 32'h0000_0000);
		repeat (3) @(posedge clk);
		@(negedge clk);
		check(32'(irq), 32'h0000_0000, "irq off");
		$display("interrupt test done");
		summarize();
	end
endmodule
bind pmx_pin_mux_top pmx_pin_mux_props u_pmx_pin_mux_props (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
	.padIn(padIn), .padOut(padOut), .padOe(padOe), .canPort0Transmit(canPort0Transmit),
	.i2cCh0ClockLow(i2cCh0ClockLow), .adcUnit0ConversionStart(adcUnit0ConversionStart),
	.canPort0Receive(canPort0Receive), .irqRequest(irqRequest));
